// file: hdl/mac_pkg.sv
// package of constants and the state type for the multiply-accumulate unit
// assumes an apb master on the same clock as the unit
//
// Overview of operation
// (RULE1) two signed 8-bit write-only multiply operands
// (RULE2) first operand write loads multiplier, reads zero
// (RULE3) product high byte readable at its address
// (RULE4) product low byte readable at its address
// (RULE5) first accumulate operand feeds accumulate multiply
// (RULE6) first accumulate address reads accumulator byte 1
// (RULE7) second accumulate operand feeds accumulate multiply
// (RULE8) second accumulate address reads accumulator byte 0
// (RULE9) first clear address reads accumulator byte 3
// (RULE10) second clear address reads accumulator byte 2
// (RULE11) any write with byte lane 0 strobe set to either clear zeroes accumulator
// (RULE12) product tracks new operand times other operand
// (RULE13) accumulate write adds sign-extended product, wrapping
package mac_pkg;

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0] MAC1_MUL_OPERAND_FIRST_IDX = 8'ha8;
	localparam logic [7:0] MAC1_MUL_OPERAND_SECOND_IDX = 8'ha9;
	localparam logic [7:0] MAC1_PRODUCT_HIGH_IDX = 8'haa;
	localparam logic [7:0] MAC1_PRODUCT_LOW_IDX = 8'hab;
	localparam logic [7:0] MAC1_ACC_OPERAND_FIRST_BYTE1_IDX = 8'hac;
	localparam logic [7:0] MAC1_ACC_OPERAND_SECOND_BYTE0_IDX = 8'had;
	localparam logic [7:0] MAC1_CLEAR_A_BYTE3_IDX = 8'hae;
	localparam logic [7:0] MAC1_CLEAR_B_BYTE2_IDX = 8'haf;
	localparam logic [7:0] MAC0_MUL_OPERAND_FIRST_IDX = 8'he8;
	localparam logic [7:0] MAC0_MUL_OPERAND_SECOND_IDX = 8'he9;
	localparam logic [7:0] MAC0_PRODUCT_HIGH_IDX = 8'hea;
	localparam logic [7:0] MAC0_PRODUCT_LOW_IDX = 8'heb;
	localparam logic [7:0] MAC0_ACC_OPERAND_FIRST_BYTE1_IDX = 8'hec;
	localparam logic [7:0] MAC0_ACC_OPERAND_SECOND_BYTE0_IDX = 8'hed;
	localparam logic [7:0] MAC0_CLEAR_A_BYTE3_IDX = 8'hee;
	localparam logic [7:0] MAC0_CLEAR_B_BYTE2_IDX = 8'hef;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam int UNITS = 2;
	localparam logic [7:0] OPERAND_RESET = 8'h00;
	localparam logic [31:0] ACC_RESET = 32'h0000_0000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// all state of the unit
	// ------------------------------------------------------------
	typedef struct packed {
		logic [UNITS-1:0][7:0] mul_a;
		logic [UNITS-1:0][7:0] mul_b;
		logic [UNITS-1:0][7:0] acc_a;
		logic [UNITS-1:0][7:0] acc_b;
		logic [UNITS-1:0][31:0] acc;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} state_t;

endpackage

// file: hdl/multiply_accumulate_unit.sv
// two multiply-accumulate units behind one apb slave
// assumes an apb master on mclk; no wait states, pready high in the first access cycle
`timescale 1ns/1ps
`default_nettype none

module multiply_accumulate_unit
	import mac_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ------------------------------------------------------------
	// decode and arithmetic per unit
	// ------------------------------------------------------------
	state_t q;
	state_t d;
	logic [7:0] idx;
	logic setup;
	logic wr;
	logic [UNITS-1:0] hit;
	logic [UNITS-1:0][7:0] rd_val;
	logic [UNITS-1:0][15:0] prod;
	logic [UNITS-1:0][31:0] acc_next;
	logic [UNITS-1:0] wr_mul_a;
	logic [UNITS-1:0] wr_mul_b;
	logic [UNITS-1:0] wr_acc_a;
	logic [UNITS-1:0] wr_acc_b;
	logic [UNITS-1:0] wr_clear;
	logic access;
	logic done;
	logic rd_setup;
	logic lane0;
	logic [31:0] rd_word;

	// ------------------------------------------------------------
	// bus phases
	// ------------------------------------------------------------
	assign idx = paddr[ADDR_W-1:2];
	assign setup = psel & ~penable;
	assign access = psel & penable;
	// pready is a register, so the access cycle it marks is the answered one
	assign done = access & q.ready;
	assign rd_setup = setup & ~pwrite;
	// only byte lane 0 carries a register, so only its strobe counts
	assign lane0 = pstrb[0];
	// write lands only at the edge where pready is seen high
	assign wr = done & pwrite & lane0;

	// ------------------------------------------------------------
	// per unit decode, arithmetic and read mux
	// ------------------------------------------------------------
	genvar u;
	generate
		for (u = 0; u < UNITS; u++) begin : g_unit
			// register indices of this unit
			localparam logic [7:0] MF = (u == 0) ? MAC0_MUL_OPERAND_FIRST_IDX
				: MAC1_MUL_OPERAND_FIRST_IDX;
			localparam logic [7:0] MS = (u == 0) ? MAC0_MUL_OPERAND_SECOND_IDX
				: MAC1_MUL_OPERAND_SECOND_IDX;
			localparam logic [7:0] PH = (u == 0) ? MAC0_PRODUCT_HIGH_IDX
				: MAC1_PRODUCT_HIGH_IDX;
			localparam logic [7:0] PL = (u == 0) ? MAC0_PRODUCT_LOW_IDX
				: MAC1_PRODUCT_LOW_IDX;
			localparam logic [7:0] AF = (u == 0) ? MAC0_ACC_OPERAND_FIRST_BYTE1_IDX
				: MAC1_ACC_OPERAND_FIRST_BYTE1_IDX;
			localparam logic [7:0] AS = (u == 0) ? MAC0_ACC_OPERAND_SECOND_BYTE0_IDX
				: MAC1_ACC_OPERAND_SECOND_BYTE0_IDX;
			localparam logic [7:0] CA = (u == 0) ? MAC0_CLEAR_A_BYTE3_IDX
				: MAC1_CLEAR_A_BYTE3_IDX;
			localparam logic [7:0] CB = (u == 0) ? MAC0_CLEAR_B_BYTE2_IDX
				: MAC1_CLEAR_B_BYTE2_IDX;

			// address selects
			logic sel_mul_a;
			logic sel_mul_b;
			logic sel_prod_hi;
			logic sel_prod_lo;
			logic sel_acc_a;
			logic sel_acc_b;
			logic sel_clr_a;
			logic sel_clr_b;

			// multiply path
			logic signed [7:0] mul_x;
			logic signed [7:0] mul_y;
			logic signed [15:0] mul_p;

			// accumulate path
			logic [7:0] a_new;
			logic [7:0] b_new;
			logic signed [7:0] acc_x;
			logic signed [7:0] acc_y;
			logic signed [15:0] acc_p;
			logic [31:0] acc_ext;

			// accumulator byte views
			logic [7:0] acc_byte0;
			logic [7:0] acc_byte1;
			logic [7:0] acc_byte2;
			logic [7:0] acc_byte3;

			// one compare per register, shared by read and write
			assign sel_mul_a = (idx == MF);
			assign sel_mul_b = (idx == MS);
			assign sel_prod_hi = (idx == PH);
			assign sel_prod_lo = (idx == PL);
			assign sel_acc_a = (idx == AF);
			assign sel_acc_b = (idx == AS);
			assign sel_clr_a = (idx == CA);
			assign sel_clr_b = (idx == CB);

			// any select means the index belongs to this unit
			assign hit[u] = sel_mul_a
				| sel_mul_b
				| sel_prod_hi
				| sel_prod_lo
				| sel_acc_a
				| sel_acc_b
				| sel_clr_a
				| sel_clr_b;

			// write strobes
			assign wr_mul_a[u] = wr & sel_mul_a; // [RULE2]
			assign wr_mul_b[u] = wr & sel_mul_b; // [RULE1]
			assign wr_acc_a[u] = wr & sel_acc_a; // [RULE5]
			assign wr_acc_b[u] = wr & sel_acc_b; // [RULE7]
			// both clear addresses share one strobe, data ignored
			assign wr_clear[u] = wr & (sel_clr_a | sel_clr_b); // [RULE11]

			// signed 8x8, product follows whichever operand moved last
			assign mul_x = q.mul_a[u]; // [RULE1]
			assign mul_y = q.mul_b[u]; // [RULE1]
			assign mul_p = mul_x * mul_y; // [RULE12]
			assign prod[u] = mul_p;

			// use the word being written so the add sees the new operand
			assign a_new = wr_acc_a[u] ? pwdata[7:0] : q.acc_a[u]; // [RULE5]
			assign b_new = wr_acc_b[u] ? pwdata[7:0] : q.acc_b[u]; // [RULE7]

			assign acc_x = a_new;
			assign acc_y = b_new;
			assign acc_p = acc_x * acc_y;
			// sign extension keeps negative products negative in the sum
			assign acc_ext = {{16{acc_p[15]}}, acc_p}; // [RULE13]
			// 32-bit add wraps on overflow
			assign acc_next[u] = q.acc[u] + acc_ext; // [RULE13]

			// byte views of the running sum, no snapshot between reads
			assign acc_byte0 = q.acc[u][7:0];
			assign acc_byte1 = q.acc[u][15:8];
			assign acc_byte2 = q.acc[u][23:16];
			assign acc_byte3 = q.acc[u][31:24];

			// read mux; write-only operands and unknown indices read as zero
			always_comb begin
				rd_val[u] = 8'h00;
				case (1'b1)
					sel_mul_a: begin
						rd_val[u] = 8'h00; // [RULE2]
					end
					sel_mul_b: begin
						rd_val[u] = 8'h00; // [RULE1]
					end
					sel_prod_hi: begin
						rd_val[u] = prod[u][15:8]; // [RULE3]
					end
					sel_prod_lo: begin
						rd_val[u] = prod[u][7:0]; // [RULE4]
					end
					sel_acc_a: begin
						rd_val[u] = acc_byte1; // [RULE6]
					end
					sel_acc_b: begin
						rd_val[u] = acc_byte0; // [RULE8]
					end
					sel_clr_a: begin
						rd_val[u] = acc_byte3; // [RULE9]
					end
					sel_clr_b: begin
						rd_val[u] = acc_byte2; // [RULE10]
					end
					default: begin
						rd_val[u] = 8'h00;
					end
				endcase
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// read word
	// ------------------------------------------------------------
	// units never overlap in the map, so at most one hit is set
	always_comb begin
		rd_word = RDATA_RESET;
		for (int i = 0; i < UNITS; i++) begin
			if (hit[i]) begin
				rd_word = {24'h000000, rd_val[i]};
			end
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;

		// pready raised for exactly the access cycle after setup
		d.ready = setup;

		// answer latched at setup, stands until the next setup
		if (setup) begin
			d.slverr = ~(|hit);
			d.rdata = RDATA_RESET;
		end
		if (rd_setup) begin
			d.rdata = rd_word;
		end

		// operand and accumulator fields
		for (int i = 0; i < UNITS; i++) begin
			if (wr_mul_a[i]) begin
				d.mul_a[i] = pwdata[7:0]; // [RULE2]
			end
			if (wr_mul_b[i]) begin
				d.mul_b[i] = pwdata[7:0]; // [RULE1]
			end
			if (wr_acc_a[i]) begin
				d.acc_a[i] = pwdata[7:0]; // [RULE5]
			end
			if (wr_acc_b[i]) begin
				d.acc_b[i] = pwdata[7:0]; // [RULE7]
			end
			if (wr_acc_a[i] || wr_acc_b[i]) begin
				d.acc[i] = acc_next[i]; // [RULE13]
			end else if (wr_clear[i]) begin
				d.acc[i] = ACC_RESET; // data ignored [RULE11]
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			q.mul_a <= {UNITS{OPERAND_RESET}};
			q.mul_b <= {UNITS{OPERAND_RESET}};
			q.acc_a <= {UNITS{OPERAND_RESET}};
			q.acc_b <= {UNITS{OPERAND_RESET}};
			q.acc <= {UNITS{ACC_RESET}};
			q.rdata <= RDATA_RESET;
			q.ready <= 1'b0;
			q.slverr <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// outputs straight from the state register
	// ------------------------------------------------------------
	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.slverr;

endmodule

`default_nettype wire

// file: verification/apb_host_model.sv
// apb master standing in for the processor core
// assumes tasks are called from the bench, one transfer at a time
`timescale 1ns/1ps
`default_nettype none
module apb_host_model
	import mac_pkg::*;
(
	// clock
	input wire logic mclk,
	// request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	// answer
	input wire logic [31:0] prdata,
	input wire logic pready
);
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
	end
	// ----
	// one transfer, held until pready
	// ----
	task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] q);
		@(posedge mclk);
		{psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, i, 2'b00, 24'h0, d, 4'hf};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		// idle address and data scrambled so nothing leans on stale values
		{psel, penable, paddr, pwdata} <= {2'b00, ~paddr, ~pwdata};
	endtask
endmodule
`default_nettype wire

// file: verification/mac_monitor.sv
// port checker for the multiply-accumulate unit
// assumes a bind onto the top module, single clock domain
`timescale 1ns/1ps
`default_nettype none
module mac_monitor
	import mac_pkg::*;
(
	// bus
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	wire logic [7:0] idx = paddr[9:2];
	wire logic setup = psel && !penable;
	wire logic hit = idx[7] && idx[5] && !idx[4] && idx[3];
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ----
	// checks
	// ----
	sequence clr_done; psel && penable && pready && pwrite && idx[7:1] == 7'h77; endsequence
	sequence rd_low; setup && !pwrite && idx == 8'hed; endsequence
	ready_one_a: assert property (pready |=> !pready) else $error("pready held");
	ready_setup_a: assert property (setup |=> pready) else $error("no answer after setup");
	ready_cause_a: assert property ($rose(pready) |-> $past(setup)) else $error("stray pready");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
	wo_read_a: assert property (setup && !pwrite && hit && idx[2:1] == 2'b00 |=> prdata == 32'h0)
		else $error("operand readable");
	err_unmapped_a: assert property (setup && !hit |=> pslverr && pready) else $error("no error");
	err_mapped_a: assert property (setup && hit |=> !pslverr) else $error("false error");
	clear_read_a: assert property (clr_done ##2 rd_low |=> prdata == 32'h0)
		else $error("clear missed");
endmodule
`default_nettype wire

// file: verification/multiply_accumulate_unit_tb.sv
// self-checking bench for the multiply-accumulate unit
// assumes the apb host model and the monitor beside it
`timescale 1ns/1ps
`default_nettype none
module multiply_accumulate_unit_tb;
	import mac_pkg::*;
	logic mclk = 0, rst = 1, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] pstrb;
	logic [7:0] b;
	int fail_count = 0, checks = 0;
	always #4 mclk = ~mclk;
	apb_host_model host_i(.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready));
	multiply_accumulate_unit multiply_accumulate_unit_i(.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	// ----
	// tasks and sequence
	// ----
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		host_i.xfer(1'b1, i, d, r);
	endtask
	task automatic chk(input logic [7:0] i, input logic [31:0] e);
		host_i.xfer(1'b0, i, 8'h00, r);
		checks++;
		if (r !== e) begin
			fail_count++;
			$display("ERROR reg %h expected %h seen %h", i, e, r);
		end
	endtask
	task automatic close_out;
		if (fail_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		for (int u = 0; u < 2; u++) begin
			b = u ? 8'ha8 : 8'he8;
			for (int k = 4; k < 8; k++) chk(b | 8'(k), 32'h0);
			wr(b, 8'hf6);
			wr(b | 8'h1, 8'h07);
			chk(b | 8'h2, 32'hff);
			chk(b | 8'h3, 32'hba);
			wr(b | 8'h1, 8'h80);
			chk(b | 8'h2, 32'h05);
			chk(b | 8'h3, 32'h00);
			chk(b, 32'h0);
			wr(b | 8'h4, 8'h80);
			wr(b | 8'h5, 8'h7f);
			chk(b | 8'h5, 32'h80);
			chk(b | 8'h4, 32'hc0);
			chk(b | 8'h7, 32'hff);
			chk(b | 8'h6, 32'hff);
			wr(b | 8'h6, 8'h00);
			chk(b | 8'h5, 32'h0);
			wr(b | 8'h4, 8'h01);
			chk(b | 8'h5, 32'h7f);
			wr(b | 8'h7, 8'h5a);
			chk(b | 8'h5, 32'h0);
		end
		chk(8'h00, 32'h0);
		close_out;
	end
	initial begin
		repeat (3000) @(posedge mclk);
		fail_count++;
		close_out;
	end
endmodule
bind multiply_accumulate_unit mac_monitor mac_monitor_i(.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
